//--- hw/exec_map.vh
/* exec_map.vh: register offsets, opcodes, exception codes, status word
   field positions, reset values and timing figures of the execution unit.
   assumes: included by bare name by the unit; byte addresses on APB. */
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define R_CMD     12'h000
`define R_SRC     12'h004
`define R_DST     12'h008
`define R_LEN     12'h00C
`define R_PSW     12'h010
`define R_MONMASK 12'h014
`define R_PERMASK 12'h018
`define R_GR2     12'h01C
`define R_OPND    12'h020
`define R_RESULT  12'h024
`define R_PGM     12'h028
`define R_MONCODE 12'h02C
`define R_STAT    12'h030
`define R_TIMER   12'h050
`define MEM_BIT   11

// ------------------------------------------------------------
// opcodes written to the command register
// ------------------------------------------------------------
`define OP_MOVE   4'h1
`define OP_CMP    4'h2
`define OP_REV    4'h3
`define OP_SCLR   4'h4
`define OP_SSET   4'h5
`define OP_RKEY   4'h6
`define OP_LKEY   4'h7
`define OP_ALIGN  4'h8
`define OP_MON    4'h9
`define OP_DEC    4'hA
`define OP_EDIT   4'hB
`define OP_CSW    4'hC
`define OP_FPX    4'hD

// ------------------------------------------------------------
// program interruption codes
// ------------------------------------------------------------
`define PC_OPER   8'h01
`define PC_PRIV   8'h02
`define PC_PROT   8'h04
`define PC_SPEC   8'h06
`define PC_DATA   8'h07
`define PC_MON    8'h40
`define PC_PER    8'h80

// ------------------------------------------------------------
// status word layout, fixed storage, widths, reset values
// ------------------------------------------------------------
`define PSW_KEY_LSB  8
`define PSW_EC_BIT   12
`define PSW_PROB_BIT 13
`define PER_MASK_BIT 6
`define PSW_RST      14'h0000
`define LEN_W        24
`define MON_CLS_LOC  9'h095
`define MON_TYP_LOC  9'h09C
`define EXT_OPS      3'h7
`define EXT_BYTES    16
`define EXT_DIGITS   28

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_KHZ       125000
`define TICK_MS       10
`define TIMER_MAX_MIN 930

`endif

//--- hw/exec_unit.v
/* exec_unit.v: execution unit for long moves and compares, reverse move,
   system mask and access key handling, alignment and monitor checks,
   decimal sign and edit protection checks, extended float decode and the
   interval timer, with a byte storage and an APB register slave.
   assumes: one clock, async low reset, APB master in the clk domain,
   io_irq and per_evt are asynchronous pins. */
`timescale 1ns/100ps
`default_nettype none
`include "exec_map.vh"
module exec_unit #(
  parameter MEM_AW   = 9,                   // storage address bits
  parameter TICK_CYC = `TICK_MS * `CLK_KHZ  // clocks per timer step
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        io_irq,
  input  wire [3:0]  per_evt,
  output reg         busy_r,
  output reg         pgm_int_r
);

  // ------------------------------------------------------------
  // states and derived figures
  // ------------------------------------------------------------
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RUN  = 2'h1;
  localparam [1:0] S_CHK  = 2'h2;
  localparam [1:0] S_MON  = 2'h3;
  localparam integer TK_LAST = TICK_CYC - 1;
  // 15.5 hours expressed in timer steps
  localparam integer TMR_MAXI = `TIMER_MAX_MIN * 60 * 1000 / `TICK_MS;
  localparam [23:0]  TMR_MAX  = TMR_MAXI[23:0];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [1:0]        st_r;       // sequencer state
  reg  [3:0]        op_r;       // operation in progress
  reg  [`LEN_W-1:0] src_r;      // second operand address
  reg  [`LEN_W-1:0] dst_r;      // first operand address
  reg  [`LEN_W-1:0] len_r;      // bytes left
  reg  [`LEN_W-1:0] chk_r;      // pre-scan index
  reg  [1:0]        k_r;        // monitor store byte
  reg  [1:0]        cc_r;       // condition code
  reg               intr_r;     // stopped for i/o
  reg  [7:0]        mask_r;     // system mask
  reg  [3:0]        key_r;      // access key
  reg               ec_r;       // extended-control mode
  reg               prob_r;     // problem state
  reg  [15:0]       cr8_r;      // monitor class masks
  reg  [3:0]        cr9_r;      // event masks
  reg  [31:0]       gr2_r;      // general register 2
  reg  [31:0]       opnd_r;     // immediate operand
  reg  [7:0]        saved_r;    // stored mask
  reg  [7:0]        mis_a_r;    // mismatch, second operand
  reg  [7:0]        mis_b_r;    // mismatch, first operand
  reg  [7:0]        pgm_r;      // program interruption code
  reg  [27:0]       mon_r;      // monitor class and type
  reg  [3:0]        perc_r;     // recorded events
  reg  [23:0]       tmr_r;      // interval timer
  reg  [20:0]       tk_r;       // step prescaler
  reg               texp_r;     // timer ran out
  reg  [1:0]        irq_sync_r; // i/o request synchroniser
  reg  [3:0]        per_s1_r;   // event synchroniser
  reg  [3:0]        per_s2_r;
  reg  [3:0]        per_s3_r;   // edge history
  reg  [7:0]        mdat [0:(1<<MEM_AW)-1]; // storage bytes
  reg               mprot[0:(1<<MEM_AW)-1]; // store-protect flags

  // ------------------------------------------------------------
  // combinational helpers
  // ------------------------------------------------------------
  wire              irq_s    = irq_sync_r[1];
  wire [3:0]        per_hit  = per_s2_r & ~per_s3_r & cr9_r;
  wire              idle     = (st_r == S_IDLE);
  wire              wr_ok    = psel & penable & pready & pwrite & ~pslverr;
  wire              cmd_go   = wr_ok & (paddr == `R_CMD) & idle;
  wire [3:0]        cop      = pwdata[3:0];
  wire [MEM_AW-1:0] ia       = paddr[MEM_AW+1:2];
  wire [`LEN_W-1:0] rev_a    = src_r + len_r - 24'h000001;
  wire [`LEN_W-1:0] chk_a    = ((op_r == `OP_EDIT) ? dst_r : src_r) + chk_r;
  wire [`LEN_W:0]   src_end  = {1'b0, src_r} + {1'b0, len_r};
  wire              overlap  = (dst_r > src_r) && ({1'b0, dst_r} < src_end);
  wire              last     = (chk_r == len_r - 24'h000001);
  reg  [`LEN_W-1:0] ra;         // read address, port a
  reg  [2:0]        amask;      // alignment mask
  reg               we_x;       // unit writes storage
  reg  [`LEN_W-1:0] wa_x;
  reg  [7:0]        wd_x;
  reg  [31:0]       rd_mux;
  reg               hit;
  wire [7:0]        rd_a     = mdat[ra[MEM_AW-1:0]];
  wire              rp_a     = mprot[ra[MEM_AW-1:0]];
  wire [7:0]        rd_b     = mdat[dst_r[MEM_AW-1:0]];
  wire              dec_bad  = (rd_a[7:4] > 4'h9) |
                               (last ? (rd_a[3:0] < 4'hA) : (rd_a[3:0] > 4'h9));
  wire              prot_bad = rp_a & (key_r != 4'h0);
  // a running operation refuses storage access and all register writes but the flag, code and timer words
  wire              err      = ~hit | (~idle & (paddr[`MEM_BIT] | (pwrite &
                               (paddr != `R_PGM) & (paddr != `R_STAT) &
                               (paddr != `R_TIMER))));

  // read address: pre-scan, backward source, else plain source
  always @* begin
    if (st_r == S_CHK)
      ra = chk_a;
    else if (st_r == S_RUN && op_r == `OP_REV)
      ra = rev_a;
    else
      ra = src_r;
  end

  // operand length code to low address bits that must be zero
  always @* begin
    case (opnd_r[1:0])
      2'h0:    amask = 3'h0;
      2'h1:    amask = 3'h1;
      2'h2:    amask = 3'h3;
      default: amask = 3'h7;
    endcase
  end

  // storage write request of the unit itself
  always @* begin
    we_x = 1'b0;
    wa_x = dst_r;
    wd_x = rd_a;
    if (st_r == S_RUN && !irq_s && len_r != 24'h000000 && op_r != `OP_CMP)
      we_x = 1'b1;
    if (st_r == S_MON) begin
      we_x = 1'b1;
      wa_x = (k_r == 2'h0) ? {15'h0000, `MON_CLS_LOC}
                           : {15'h0000, `MON_TYP_LOC} + {22'h000000, k_r};
      case (k_r)
        2'h0:    wd_x = {4'h0, mon_r[27:24]};
        2'h1:    wd_x = mon_r[23:16];
        2'h2:    wd_x = mon_r[15:8];
        default: wd_x = mon_r[7:0];
      endcase
    end
    // compare and store share one edge; the bus is locked out meanwhile
    if (cmd_go && cop == `OP_CSW && rd_b == gr2_r[7:0]) begin
      we_x = 1'b1;
      wd_x = opnd_r[7:0];
    end
  end

  // ------------------------------------------------------------
  // register read decode
  // ------------------------------------------------------------
  always @* begin
    rd_mux = 32'h00000000;
    hit    = (paddr[1:0] == 2'h0);
    if (paddr[`MEM_BIT]) begin
      rd_mux = {23'h000000, mprot[ia], mdat[ia]};
    end else begin
      case (paddr)
        `R_CMD:     rd_mux = {28'h0000000, intr_r, cc_r, ~idle};
        `R_SRC:     rd_mux = {8'h00, src_r};
        `R_DST:     rd_mux = {8'h00, dst_r};
        `R_LEN:     rd_mux = {8'h00, len_r};
        `R_PSW:     rd_mux = {18'h00000, prob_r, ec_r, key_r, mask_r};
        `R_MONMASK: rd_mux = {16'h0000, cr8_r};
        `R_PERMASK: rd_mux = {28'h0000000, cr9_r};
        `R_GR2:     rd_mux = gr2_r;
        `R_OPND:    rd_mux = opnd_r;
        `R_RESULT:  rd_mux = {8'h00, mis_b_r, mis_a_r, saved_r};
        `R_PGM:     rd_mux = {24'h000000, pgm_r};
        `R_MONCODE: rd_mux = {4'h0, mon_r};
        `R_STAT:    rd_mux = {26'h0000000, perc_r, 1'b0, texp_r} << 0;
        `R_TIMER:   rd_mux = {8'h00, tmr_r};
        default:    hit = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // apb slave: one wait state, data and error captured with pready
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers; the second stage is looked at, the event third stage only as edge history
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_sync_r <= 2'h0;
      per_s1_r   <= 4'h0;
      per_s2_r   <= 4'h0;
      per_s3_r   <= 4'h0;
    end else begin
      irq_sync_r <= {irq_sync_r[0], io_irq};
      per_s1_r   <= per_evt;
      per_s2_r   <= per_s1_r;
      per_s3_r   <= per_s2_r;
    end
  end

  // ------------------------------------------------------------
  // storage: the unit has priority, the bus only reaches it when idle
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (we_x)
      mdat[wa_x[MEM_AW-1:0]] <= wd_x;
    else if (wr_ok && paddr[`MEM_BIT]) begin
      mdat[ia]  <= pwdata[7:0];
      mprot[ia] <= pwdata[8];
    end
  end

  // ------------------------------------------------------------
  // sequencer, software registers and timer
  // ------------------------------------------------------------
  // later assignments win, so hardware sets override software clears
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r      <= S_IDLE;
      op_r      <= 4'h0;
      src_r     <= 24'h000000;
      dst_r     <= 24'h000000;
      len_r     <= 24'h000000;
      chk_r     <= 24'h000000;
      k_r       <= 2'h0;
      cc_r      <= 2'h0;
      intr_r    <= 1'b0;
      {prob_r, ec_r, key_r, mask_r} <= `PSW_RST;
      cr8_r     <= 16'h0000;
      cr9_r     <= 4'h0;
      gr2_r     <= 32'h00000000;
      opnd_r    <= 32'h00000000;
      saved_r   <= 8'h00;
      mis_a_r   <= 8'h00;
      mis_b_r   <= 8'h00;
      pgm_r     <= 8'h00;
      mon_r     <= 28'h0000000;
      perc_r    <= 4'h0;
      tmr_r     <= 24'h000000;
      tk_r      <= 21'h000000;
      texp_r    <= 1'b0;
      busy_r    <= 1'b0;
      pgm_int_r <= 1'b0;
    end else begin
      busy_r    <= ~idle;
      pgm_int_r <= (pgm_r != 8'h00);

      // timer steps once per prescaler wrap and stops at zero
      if (tk_r == TK_LAST[20:0]) begin
        tk_r <= 21'h000000;
        if (tmr_r != 24'h000000) begin
          tmr_r <= tmr_r - 24'h000001;
        end
      end else begin
        tk_r <= tk_r + 21'h000001;
      end

      // software writes
      if (wr_ok) begin
        case (paddr)
          `R_SRC:     src_r  <= pwdata[23:0];
          `R_DST:     dst_r  <= pwdata[23:0];
          `R_LEN:     len_r  <= pwdata[23:0];
          `R_PSW: begin
            mask_r <= pwdata[7:0];
            key_r  <= pwdata[`PSW_KEY_LSB+3:`PSW_KEY_LSB];
            ec_r   <= pwdata[`PSW_EC_BIT];
            prob_r <= pwdata[`PSW_PROB_BIT];
          end
          `R_MONMASK: cr8_r  <= pwdata[15:0];
          `R_PERMASK: cr9_r  <= pwdata[3:0];
          `R_GR2:     gr2_r  <= pwdata;
          `R_OPND:    opnd_r <= pwdata;
          `R_PGM:     pgm_r  <= 8'h00;
          `R_STAT: begin
            if (pwdata[0])
              texp_r <= 1'b0;
            if (pwdata[1])
              perc_r <= 4'h0;
          end
          `R_TIMER:   tmr_r  <= (pwdata > {8'h00, TMR_MAX}) ? TMR_MAX : pwdata[23:0];
          default: ;
        endcase
      end

      // expiry set sits after the software clear so that the set wins
      if (tk_r == TK_LAST[20:0] && tmr_r == 24'h000001)
        texp_r <= 1'b1;

      // program events: need ec mode, the status-word mask and the event mask
      if (ec_r && mask_r[`PER_MASK_BIT] && per_hit != 4'h0) begin
        pgm_r  <= `PC_PER;
        perc_r <= perc_r | per_hit;
      end

      case (st_r)
        S_IDLE: begin
          if (cmd_go) begin
            op_r   <= cop;
            intr_r <= 1'b0;
            cc_r   <= 2'h0;
            case (cop)
              `OP_MOVE: begin
                if (overlap)
                  cc_r <= 2'h3;
                else
                  st_r <= S_RUN;
              end
              `OP_CMP, `OP_REV:
                st_r <= S_RUN;
              `OP_DEC, `OP_EDIT: begin
                chk_r <= 24'h000000;                // scan before any store
                st_r  <= S_CHK;
              end
              `OP_SCLR, `OP_SSET, `OP_RKEY, `OP_LKEY: begin
                if (prob_r)
                  pgm_r <= `PC_PRIV;
                else if (cop == `OP_SCLR) begin
                  saved_r <= mask_r;
                  mask_r  <= mask_r & opnd_r[7:0];
                end else if (cop == `OP_SSET) begin
                  saved_r <= mask_r;
                  mask_r  <= mask_r | opnd_r[7:0];
                end else if (cop == `OP_RKEY)
                  gr2_r[7:4] <= key_r;
                else
                  key_r <= opnd_r[31] ? rd_a[7:4] : gr2_r[7:4];
              end
              `OP_ALIGN: begin
                // ordinary operands pass at any byte
                if (opnd_r[2] && (src_r[2:0] & amask) != 3'h0)
                  pgm_r <= `PC_SPEC;
              end
              `OP_MON: begin
                if (cr8_r[opnd_r[27:24]]) begin
                  pgm_r <= `PC_MON;
                  mon_r <= opnd_r[27:0];
                  k_r   <= 2'h0;
                  st_r  <= S_MON;
                end
              end
              `OP_CSW: begin
                if (rd_b != gr2_r[7:0]) begin
                  cc_r        <= 2'h1;
                  gr2_r[7:0]  <= rd_b;
                end
              end
              `OP_FPX: begin
                if (opnd_r[2:0] >= `EXT_OPS)
                  pgm_r <= `PC_OPER;
                else if (opnd_r[5:4] != 2'h0)
                  pgm_r <= `PC_SPEC;
              end
              default:
                pgm_r <= `PC_OPER;
            endcase
          end
        end
        S_CHK: begin
          if (chk_r == len_r) begin
            chk_r <= 24'h000000;
            st_r  <= S_RUN;
          end else if (op_r == `OP_EDIT && prot_bad) begin
            pgm_r <= `PC_PROT;
            st_r  <= S_IDLE;
          end else if (op_r == `OP_DEC && dec_bad) begin
            pgm_r <= `PC_DATA;
            st_r  <= S_IDLE;
          end else begin
            chk_r <= chk_r + 24'h000001;
          end
        end
        S_RUN: begin
          if (irq_s) begin
            intr_r <= 1'b1;
            st_r   <= S_IDLE;
          end else if (len_r == 24'h000000) begin
            st_r <= S_IDLE;
          end else if (op_r == `OP_CMP && rd_a != rd_b) begin
            mis_a_r <= rd_a;
            mis_b_r <= rd_b;
            cc_r    <= (rd_b < rd_a) ? 2'h1 : 2'h2;
            st_r    <= S_IDLE;
          end else begin
            len_r <= len_r - 24'h000001;
            dst_r <= dst_r + 24'h000001;
            if (op_r != `OP_REV)
              src_r <= src_r + 24'h000001;
          end
        end
        default: begin
          k_r <= k_r + 2'h1;
          if (k_r == 2'h3)
            st_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- tb/exec_unit_props.sv
/* exec_unit_props.sv: port-level assertions for the execution unit.
   assumes: bound to exec_unit, one clock, nrst async active low. */
`timescale 1ns/100ps
`default_nettype none
module exec_unit_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        io_irq,
  input wire logic [3:0]  per_evt,
  input wire logic        busy_r,
  input wire logic        pgm_int_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // bus answer timing
  // ----------------------------------------
  a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside access phase");
  a_err_qual: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  // unmapped or unaligned register places are refused
  a_unmapped_err: assert property (pready && !paddr[11] && (paddr[1:0] != 2'h0
    || (paddr > 12'h030 && paddr != 12'h050)) |-> pslverr)
    else $error("unmapped access not refused");
  a_reset_quiet: assert property ($rose(nrst) |-> !pready && !busy_r && !pgm_int_r)
    else $error("outputs active after reset");
  // a long loop must yield soon after an i/o request
  a_io_yield: assert property ($rose(io_irq) && busy_r |-> ##[1:8] !busy_r)
    else $error("loop kept running after i/o request");
endmodule
bind exec_unit exec_unit_props exec_unit_props_inst (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .io_irq(io_irq), .per_evt(per_evt),
  .busy_r(busy_r), .pgm_int_r(pgm_int_r));
`default_nettype wire

//--- tb/insn_exec_rules_and_checks_test.sv
/* insn_exec_rules_and_checks_test.sv: self-checking bench of exec_unit.
   assumes: exec_map.vh on the include path, APB master driven here. */
`timescale 1ns/100ps
`default_nettype none
`include "exec_map.vh"
module insn_exec_rules_and_checks_test;
  logic        clk, nrst, psel, penable, pwrite, io_irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [3:0]  per_evt, c;
  logic [7:0]  m[0:63], pm, ms, x;
  logic [23:0] t;
  wire  [31:0] prdata;
  wire         pready, pslverr, busy_r, pgm_int_r;
  int          n_mismatch, checks_done, cyc, i;
  // short timer step keeps the countdown test brief
  exec_unit #(.TICK_CYC(10)) exec_unit_inst (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_irq(io_irq), .per_evt(per_evt),
    .busy_r(busy_r), .pgm_int_r(pgm_int_r));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] xv);
    checks_done++;
    if (v !== xv) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, xv, v);
    end
  endtask
  task print_verdict;
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one apb transfer; waits on pready, releases, lets an edge pass
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [11:0] ma(input int a);
    return 12'h800 + 12'(a * 4);
  endfunction
  task automatic setup(input int s, input int d, input int l);
    apb(1'b1, `R_SRC, s);
    apb(1'b1, `R_DST, d);
    apb(1'b1, `R_LEN, l);
  endtask
  task automatic wt;
    do begin
      apb(1'b0, `R_CMD, 32'h0);
    end while (q[0] !== 1'b0);
  endtask
  task automatic op(input logic [3:0] o, input logic [31:0] d);
    apb(1'b1, `R_OPND, d);
    apb(1'b1, `R_CMD, {28'h0, o});
    wt();
  endtask
  // program code read, flag compare, then clear
  task automatic pgm(input logic [7:0] xp);
    apb(1'b0, `R_PGM, 32'h0);
    chk("pgm code", q, {24'h0, xp});
    chk("pgm flag", {31'h0, pgm_int_r}, {31'h0, xp != 8'h0});
    apb(1'b1, `R_PGM, 32'h0);
  endtask
  // ----------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    {nrst, psel, penable, pwrite, io_irq, per_evt, paddr, pwdata} = '0;
    cyc = 0;
    void'($urandom(32'hffc7b3aa));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, `R_PSW, 32'h0);
    chk("psw reset", q, 32'h0);
    apb(1'b0, 12'h034, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    for (i = 0; i < 64; i++) begin
      m[i] = $urandom;
      apb(1'b1, ma(i), {24'h0, m[i]});
    end
    setup(0, 32, 8);
    op(`OP_MOVE, 0);
    for (i = 0; i < 8; i++) begin
      apb(1'b0, ma(32 + i), 32'h0);
      chk("move", q, {24'h0, m[i]});
      m[32 + i] = m[i];
    end
    setup(8, 48, 4);
    op(`OP_REV, 0);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, ma(48 + i), 32'h0);
      chk("reverse", q, {24'h0, m[11 - i]});
    end
    setup(0, 2, 4);
    op(`OP_MOVE, 0);
    chk("overlap cc", q[2:1], 3);
    apb(1'b0, ma(2), 32'h0);
    chk("overlap data", q, {24'h0, m[2]});
    x = m[5] ^ 8'h01;
    apb(1'b1, ma(37), {24'h0, x});
    setup(0, 32, 8);
    op(`OP_CMP, 0);
    chk("cmp cc", q[2:1], (x < m[5]) ? 1 : 2);
    apb(1'b0, `R_RESULT, 32'h0);
    chk("cmp bytes", q[23:8], {x, m[5]});
    apb(1'b1, `R_DST, 32'd40);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `R_GR2, {24'h0, m[40]});
      op(`OP_CSW, {24'h0, ~m[40]});
      chk("swap cc", q[2:1], i);
      apb(1'b0, ma(40), 32'h0);
      chk("swap byte", q[7:0], {~m[40]});
      apb(1'b0, `R_GR2, 32'h0);
      chk("swap reg", q[7:0], i ? {~m[40]} : m[40]);
    end
    setup(0, 256, 200);
    apb(1'b1, `R_CMD, {28'h0, `OP_MOVE});
    repeat (20) @(posedge clk);
    io_irq <= 1'b1;
    wt();
    chk("io intr", q[3], 1);
    apb(1'b0, `R_LEN, 32'h0);
    chk("len held", {31'h0, q > 0 && q < 200}, 1);
    io_irq <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, `R_CMD, {28'h0, `OP_MOVE});
    wt();
    apb(1'b0, `R_LEN, 32'h0);
    chk("resume", q, 0);
    for (i = 0; i < 2; i++) begin
      pm = $urandom;
      ms = $urandom;
      apb(1'b1, `R_PSW, {24'h0, pm});
      op(i ? `OP_SSET : `OP_SCLR, ms);
      apb(1'b0, `R_RESULT, 32'h0);
      chk("saved mask", q[7:0], pm);
      apb(1'b0, `R_PSW, 32'h0);
      chk("new mask", q[7:0], i ? pm | ms : pm & ms);
    end
    c = $urandom;
    apb(1'b1, `R_PSW, {20'h0, c, 8'h0});
    op(`OP_RKEY, 0);
    apb(1'b0, `R_GR2, 32'h0);
    chk("read key", q[7:4], c);
    apb(1'b1, `R_GR2, {24'h0, ~c, 4'h0});
    op(`OP_LKEY, 0);
    apb(1'b0, `R_PSW, 32'h0);
    chk("load key", q[11:8], {~c});
    apb(1'b1, `R_SRC, 32'h8);
    op(`OP_LKEY, 32'h80000000);
    apb(1'b0, `R_PSW, 32'h0);
    chk("load key mem", q[11:8], m[8][7:4]);
    apb(1'b1, `R_PSW, 32'h2000);
    op(`OP_SCLR, 0);
    pgm(`PC_PRIV);
    apb(1'b1, `R_PSW, 32'h100);
    apb(1'b1, ma(61), {23'h0, 1'b1, m[61]});
    setup(0, 61, 1);
    op(`OP_EDIT, 0);
    pgm(`PC_PROT);
    apb(1'b0, ma(61), 32'h0);
    chk("edit kept", q[7:0], m[61]);
    apb(1'b1, `R_PSW, 32'h0);
    apb(1'b1, ma(56), 32'h12);
    apb(1'b1, ma(57), 32'h34);
    setup(56, 60, 2);
    op(`OP_DEC, 0);
    pgm(`PC_DATA);
    apb(1'b0, ma(60), 32'h0);
    chk("dec kept", q, {24'h0, m[60]});
    apb(1'b1, `R_SRC, 32'h1);
    for (i = 0; i < 8; i++) begin
      op(`OP_ALIGN, i);
      pgm((i > 4 || i == 5) && i[1:0] != 0 ? `PC_SPEC : 8'h0);
    end
    c = $urandom;
    t = $urandom;
    apb(1'b1, `R_MONMASK, 32'h1 << c);
    op(`OP_MON, {4'h0, c, t});
    pgm(`PC_MON);
    apb(1'b0, `R_MONCODE, 32'h0);
    chk("mon code", q[27:0], {c, t});
    apb(1'b0, ma(149), 32'h0);
    chk("mon class byte", q[7:0], {4'h0, c});
    for (i = 0; i < 3; i++) begin
      apb(1'b0, ma(157 + i), 32'h0);
      chk("mon type byte", q[7:0], t[23 - 8 * i -: 8]);
    end
    op(`OP_MON, {4'h0, c + 4'h1, t});
    pgm(8'h0);
    for (i = 0; i < 9; i++) begin
      op(`OP_FPX, i < 8 ? i : 32'h10);
      pgm(i == 7 ? `PC_OPER : (i == 8 ? `PC_SPEC : 8'h0));
    end
    // program events: ec off first, then ec on; bit 0 always pulsed
    apb(1'b1, `R_PERMASK, 32'h5);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `R_PSW, i ? 32'h1040 : 32'h0040);
      c = $urandom | 1;
      per_evt <= c;
      repeat (4) @(posedge clk);
      per_evt <= 4'h0;
      pgm(i ? `PC_PER : 8'h0);
      apb(1'b0, `R_STAT, 32'h0);
      chk("event bits", q[5:2], i ? c & 4'h5 : 0);
      apb(1'b1, `R_STAT, 32'h2);
    end
    apb(1'b0, `R_STAT, 32'h0);
    chk("event clear", q[5:2], 0);
    apb(1'b1, `R_TIMER, 32'hFFFFFF);
    apb(1'b0, `R_TIMER, 32'h0);
    // the free-running step may fall once between write and read
    chk("timer clamp", {31'h0, q inside {32'd5580000, 32'd5579999}}, 32'h1);
    apb(1'b1, `R_TIMER, 32'h3);
    repeat (50) @(posedge clk);
    apb(1'b0, `R_TIMER, 32'h0);
    chk("timer run", q, 0);
    apb(1'b0, `R_STAT, 32'h0);
    chk("timer flag", q[0], 1);
    apb(1'b1, `R_STAT, 32'h1);
    apb(1'b0, `R_STAT, 32'h0);
    chk("timer flag clear", q[0], 0);
    print_verdict();
  end
endmodule
`default_nettype wire
